//--- core/ppds_pkg.sv
// Purpose: shared constants and types of the parallel port data/status block
// Assumes: APB with 32-bit data, byte addresses on 8 address bits
// Notes: one aligned word per register, upper bits read as zero
package ppds_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int SLOTS = 4;

    localparam logic [ADDR_W-1:0] ADDR_OUT_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_IN_DATA = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE = 8'h10;
    localparam logic [3:0] SLOT_PAGE = 4'h2;

    localparam int ST_ALL_IN_FULL = 15;
    localparam int ST_IN_OVR = 14;
    localparam int ST_IN_FULL_LO = 8;
    localparam int ST_ALL_OUT_EMPTY = 7;
    localparam int ST_OUT_UNR = 6;
    localparam int ST_OUT_EMPTY_LO = 0;

    localparam int CTL_MASTER = 0;
    localparam int CTL_DUAL = 1;
    localparam int CTL_WIDE = 2;
    localparam int CTL_BUSY = 8;

    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [DATA_W-1:0] NARROW_MASK = 16'h00FF;
    localparam logic [SLOTS-1:0] IN_FULL_RST = 4'h0;
    localparam logic [SLOTS-1:0] OUT_EMPTY_RST = 4'hF;

    localparam int CLK_NS = 100;
    localparam int STROBE_NS = 300;
    localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {XF_IDLE, XF_WRITE, XF_READ} ppds_xfer_t;
endpackage : ppds_pkg

//--- core/ppds_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are quasi-static across a couple of clocks
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module ppds_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ppds_sync_st_t;

    ppds_sync_st_t st_r;
    ppds_sync_st_t st_nxt;

    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule : ppds_sync

//--- core/ppds_slots.sv
// Purpose: four input and four output byte slots for slave operation
// Assumes: strobes are one-cycle pulses from the same clock
// Notes: hardware set of a flag wins over a clear in the same cycle
`timescale 1ns/1ps
module ppds_slots
    import ppds_pkg::*;
#(
    parameter int NSLOT = ppds_pkg::SLOTS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ext_wr,
    input wire logic ext_rd,
    input wire logic [$clog2(NSLOT)-1:0] ext_sel,
    input wire logic [7:0] ext_byte,
    input wire logic [NSLOT-1:0] sw_load,
    input wire logic [NSLOT*8-1:0] load_data,
    input wire logic [NSLOT-1:0] sw_take,
    input wire logic ovr_clr,
    input wire logic unr_clr,
    output logic [NSLOT*8-1:0] in_bytes,
    output logic [NSLOT-1:0] in_full,
    output logic [NSLOT-1:0] out_empty,
    output logic in_ovr,
    output logic out_unr,
    output logic [7:0] rd_byte
);
    typedef struct packed {
        logic [NSLOT-1:0][7:0] in_mem;
        logic [NSLOT-1:0][7:0] out_mem;
        logic [NSLOT-1:0] in_full;
        logic [NSLOT-1:0] out_empty;
        logic in_ovr;
        logic out_unr;
    } ppds_slots_st_t;

    ppds_slots_st_t st_r;
    ppds_slots_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (ovr_clr) begin
            st_nxt.in_ovr = 1'b0;
        end
        if (unr_clr) begin
            st_nxt.out_unr = 1'b0;
        end
        for (int k = 0; k < NSLOT; k++) begin
            if (sw_load[k]) begin
                st_nxt.out_mem[k] = load_data[k*8 +: 8];
                st_nxt.out_empty[k] = 1'b0;
            end
            if (sw_take[k]) begin
                st_nxt.in_full[k] = 1'b0;
            end
        end
        if (ext_wr) begin
            if (st_r.in_full[ext_sel] && !sw_take[ext_sel]) begin
                st_nxt.in_ovr = 1'b1;
            end else begin
                st_nxt.in_mem[ext_sel] = ext_byte;
                st_nxt.in_full[ext_sel] = 1'b1;
            end
        end
        if (ext_rd) begin
            if (st_r.out_empty[ext_sel]) begin
                st_nxt.out_unr = 1'b1;
            end else begin
                st_nxt.out_empty[ext_sel] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.in_full <= IN_FULL_RST;
            st_r.out_empty <= OUT_EMPTY_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_bytes = st_r.in_mem;
    assign in_full = st_r.in_full;
    assign out_empty = st_r.out_empty;
    assign in_ovr = st_r.in_ovr;
    assign out_unr = st_r.out_unr;
    assign rd_byte = st_r.out_mem[ext_sel];
endmodule : ppds_slots

//--- core/ppds_top.sv
// Purpose: APB data/status registers and external port of a parallel port
// Assumes: external strobes are asynchronous and held at least 3 clocks
// Notes: zero-wait APB slave, read data captured in the setup cycle
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module ppds_top
    import ppds_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ppds_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_cs_n,
    input wire logic ext_rd_n,
    input wire logic ext_wr_n,
    input wire logic [1:0] ext_addr,
    input wire logic [ppds_pkg::DATA_W-1:0] ext_din,
    output logic [ppds_pkg::DATA_W-1:0] ext_dout,
    output logic ext_doe,
    output logic port_rd_n,
    output logic port_wr_n
);
    import ppds_pkg::*;

    localparam int PIN_W = 3 + 2 + DATA_W;

    typedef struct packed {
        logic [DATA_W-1:0] out_data;
        logic [DATA_W-1:0] in_data;
        logic [DATA_W-1:0] capture;
        logic master;
        logic dual;
        logic wide;
        ppds_xfer_t xf;
        logic [3:0] cnt;
        logic [DATA_W-1:0] pdout;
        logic pdoe;
        logic prd_n;
        logic pwr_n;
        logic [31:0] rdata;
        logic slverr;
        logic rd_n_q;
        logic wr_n_q;
    } ppds_top_st_t;

    ppds_top_st_t st_r;
    ppds_top_st_t st_nxt;

    function automatic logic msb_hit(input logic [3:0] s, input logic w);
        msb_hit = w ? s[1] : s[0];
    endfunction : msb_hit

    function automatic logic [DATA_W-1:0] merge16(input logic [DATA_W-1:0] o,
        input logic [DATA_W-1:0] n, input logic [1:0] s);
        merge16 = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
    endfunction : merge16

    function automatic logic is_slot(input logic [ADDR_W-1:0] a);
        is_slot = (a[7:4] == SLOT_PAGE) && (a[1:0] == 2'b00);
    endfunction : is_slot

    logic [PIN_W-1:0] pins_s;
    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    logic [1:0] sel_s;
    logic [DATA_W-1:0] din_s;

    ppds_sync #(
        .W(PIN_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({ext_cs_n, ext_rd_n, ext_wr_n, ext_addr, ext_din}),
        .q(pins_s)
    );

    assign {cs_n_s, rd_n_s, wr_n_s, sel_s, din_s} = pins_s;

    logic wr_acc;
    logic rd_acc;
    logic idle;
    logic start_dual;
    logic start_in_wr;
    logic start_in_rd;
    logic ext_wr_p;
    logic ext_rd_p;
    logic slot_acc;
    logic [1:0] slot_idx;
    logic [SLOTS-1:0] sw_load;
    logic [SLOTS-1:0] sw_take;
    logic [SLOTS*8-1:0] load_data;
    logic ovr_clr;
    logic unr_clr;
    logic [SLOTS*8-1:0] in_bytes;
    logic [SLOTS-1:0] in_full;
    logic [SLOTS-1:0] out_empty;
    logic in_ovr;
    logic out_unr;
    logic [7:0] rd_byte;
    logic [31:0] status_word;
    logic [31:0] control_word;
    logic [SLOTS-1:0] sel_hot;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign idle = (st_r.xf == XF_IDLE);
    assign slot_acc = psel && penable && is_slot(paddr);
    assign slot_idx = paddr[3:2];
    assign sel_hot = 4'h1 << sel_s;
    assign start_dual = st_r.master && st_r.dual && wr_acc
        && (paddr == ADDR_OUT_DATA) && msb_hit(pstrb, st_r.wide);
    assign start_in_wr = st_r.master && !st_r.dual && wr_acc
        && (paddr == ADDR_IN_DATA) && msb_hit(pstrb, st_r.wide);
    // reads carry no strobes, so any read of this word is an MSB read
    assign start_in_rd = st_r.master && !st_r.dual && rd_acc
        && (paddr == ADDR_IN_DATA);
    // strobes act on their synchronised falling edge, slave mode only
    assign ext_wr_p = !st_r.master && !cs_n_s && st_r.wr_n_q && !wr_n_s;
    assign ext_rd_p = !st_r.master && !cs_n_s && st_r.rd_n_q && !rd_n_s;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_ALL_IN_FULL] = &in_full;
        status_word[ST_IN_OVR] = in_ovr;
        status_word[ST_IN_FULL_LO +: SLOTS] = in_full;
        status_word[ST_ALL_OUT_EMPTY] = &out_empty;
        status_word[ST_OUT_UNR] = out_unr;
        status_word[ST_OUT_EMPTY_LO +: SLOTS] = out_empty;
        control_word = 32'h0000_0000;
        control_word[CTL_MASTER] = st_r.master;
        control_word[CTL_DUAL] = st_r.dual;
        control_word[CTL_WIDE] = st_r.wide;
        control_word[CTL_BUSY] = !idle;
    end

    always_comb begin
        st_nxt = st_r;
        sw_load = '0;
        sw_take = '0;
        load_data = '0;
        ovr_clr = 1'b0;
        unr_clr = 1'b0;
        st_nxt.rd_n_q = rd_n_s;
        st_nxt.wr_n_q = wr_n_s;
        if (psel && !penable) begin
            st_nxt.slverr = 1'b0;
            st_nxt.rdata = 32'h0000_0000;
            if (paddr == ADDR_OUT_DATA) begin
                st_nxt.rdata = {16'h0000, st_r.out_data};
            end else if (paddr == ADDR_IN_DATA) begin
                st_nxt.rdata = {16'h0000, st_r.in_data};
            end else if (paddr == ADDR_STATUS) begin
                st_nxt.rdata = status_word;
            end else if (paddr == ADDR_CONTROL) begin
                st_nxt.rdata = control_word;
            end else if (paddr == ADDR_CAPTURE) begin
                st_nxt.rdata = {16'h0000, st_r.capture};
            end else if (is_slot(paddr)) begin
                st_nxt.rdata = {24'h000000, in_bytes[slot_idx*8 +: 8]};
            end else begin
                st_nxt.slverr = 1'b1;
            end
        end
        if (wr_acc) begin
            if (paddr == ADDR_OUT_DATA) begin
                st_nxt.out_data = merge16(st_r.out_data, pwdata[15:0],
                    pstrb[1:0]);
                // output data doubles as slots 0 and 1 for the external read
                if (!st_r.master) begin
                    sw_load[1:0] = pstrb[1:0];
                    load_data[15:0] = pwdata[15:0];
                end
            end else if (paddr == ADDR_IN_DATA) begin
                st_nxt.in_data = merge16(st_r.in_data, pwdata[15:0],
                    pstrb[1:0]);
            end else if (paddr == ADDR_STATUS) begin
                // flags are set only by hardware; writing zero clears
                ovr_clr = pstrb[1] && !pwdata[ST_IN_OVR];
                unr_clr = pstrb[0] && !pwdata[ST_OUT_UNR];
            end else if (paddr == ADDR_CONTROL) begin
                if (pstrb[0]) begin
                    st_nxt.master = pwdata[CTL_MASTER];
                    st_nxt.dual = pwdata[CTL_DUAL];
                    st_nxt.wide = pwdata[CTL_WIDE];
                end
            end else if (is_slot(paddr) && pstrb[0]) begin
                sw_load[slot_idx] = 1'b1;
                load_data[slot_idx*8 +: 8] = pwdata[7:0];
                if (slot_idx == 2'd0) begin
                    st_nxt.out_data[7:0] = pwdata[7:0];
                end else if (slot_idx == 2'd1) begin
                    st_nxt.out_data[15:8] = pwdata[7:0];
                end
            end
        end
        if (rd_acc && slot_acc && !st_r.master) begin
            sw_take[slot_idx] = 1'b1;
        end
        case (st_r.xf)
            XF_IDLE: begin
                // a trigger while busy is dropped; software polls busy first
                if (start_dual || start_in_wr) begin
                    st_nxt.xf = XF_WRITE;
                    st_nxt.cnt = 4'h0;
                    st_nxt.pdoe = 1'b1;
                    st_nxt.pwr_n = 1'b0;
                    st_nxt.pdout = (start_dual ? st_nxt.out_data
                        : st_nxt.in_data)
                        & (st_r.wide ? 16'hFFFF : NARROW_MASK);
                end else if (start_in_rd) begin
                    st_nxt.xf = XF_READ;
                    st_nxt.cnt = 4'h0;
                    st_nxt.prd_n = 1'b0;
                end
            end
            XF_WRITE: begin
                if (st_r.cnt == STROBE_CYC - 4'h1) begin
                    st_nxt.xf = XF_IDLE;
                    st_nxt.pwr_n = 1'b1;
                    st_nxt.pdoe = 1'b0;
                end else begin
                    st_nxt.cnt = st_r.cnt + 4'h1;
                end
            end
            XF_READ: begin
                if (st_r.cnt == STROBE_CYC - 4'h1) begin
                    st_nxt.xf = XF_IDLE;
                    st_nxt.prd_n = 1'b1;
                    st_nxt.capture = din_s
                        & (st_r.wide ? 16'hFFFF : NARROW_MASK);
                end else begin
                    st_nxt.cnt = st_r.cnt + 4'h1;
                end
            end
            default: begin
                st_nxt.xf = XF_IDLE;
            end
        endcase
        if (!st_r.master && idle) begin
            if (ext_rd_p) begin
                st_nxt.pdout = {8'h00, rd_byte};
                st_nxt.pdoe = 1'b1;
            end else if (st_r.pdoe && (rd_n_s || cs_n_s)) begin
                st_nxt.pdoe = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.out_data <= DATA_RST;
            st_r.in_data <= DATA_RST;
            st_r.capture <= DATA_RST;
            st_r.prd_n <= 1'b1;
            st_r.pwr_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ppds_slots #(
        .NSLOT(SLOTS)
    ) u_slots (
        .pclk(pclk),
        .presetn(presetn),
        .ext_wr(ext_wr_p),
        .ext_rd(ext_rd_p),
        .ext_sel(sel_s),
        .ext_byte(din_s[7:0]),
        .sw_load(sw_load),
        .load_data(load_data),
        .sw_take(sw_take),
        .ovr_clr(ovr_clr),
        .unr_clr(unr_clr),
        .in_bytes(in_bytes),
        .in_full(in_full),
        .out_empty(out_empty),
        .in_ovr(in_ovr),
        .out_unr(out_unr),
        .rd_byte(rd_byte)
    );

    assign prdata = st_r.rdata;
    assign pready = 1'b1;
    assign pslverr = st_r.slverr;
    assign ext_dout = st_r.pdout;
    assign ext_doe = st_r.pdoe;
    assign port_rd_n = st_r.prd_n;
    assign port_wr_n = st_r.pwr_n;
    logic [7:0] out_lo;
    logic [DATA_W-1:0] in_data_q;
    assign out_lo = st_r.out_data[7:0];
    assign in_data_q = st_r.in_data;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_DATA_HI_ZERO: assert property (
        psel && !penable && (paddr == ADDR_OUT_DATA || paddr == ADDR_IN_DATA)
        |=> prdata[31:16] == 16'h0000)
        else $error("data register upper half not zero");
    AST_DUAL_START: assert property (
        idle && start_dual |=> !port_wr_n [*3] ##1 port_wr_n)
        else $error("dual buffer write strobe wrong");
    AST_NARROW_MSB: assert property (
        idle && st_r.master && st_r.dual && !st_r.wide && wr_acc
        && paddr == ADDR_OUT_DATA && pstrb == 4'h2 |=> port_wr_n)
        else $error("narrow bus started on upper byte");
    AST_SLAVE_OUT: assert property (
        idle && ext_rd_p && sel_s == 2'b00 && !out_empty[0]
        |=> ext_doe && ext_dout[7:0] == $past(out_lo))
        else $error("slave read did not return output data");
    AST_IN_WR_START: assert property (
        idle && start_in_wr |=> !port_wr_n && ext_doe)
        else $error("input register write did not start port write");
    AST_IN_RD_START: assert property (
        idle && start_in_rd |=> !port_rd_n [*3] ##1 port_rd_n)
        else $error("input register read did not start port read");
    AST_DUAL_IN_QUIET: assert property (
        idle && st_r.master && st_r.dual && psel && penable
        && paddr == ADDR_IN_DATA |=> idle)
        else $error("input register used in dual buffer mode");
    AST_IN_READBACK: assert property (
        wr_acc && paddr == ADDR_IN_DATA && pstrb == 4'hF
        |=> in_data_q == $past(pwdata[15:0]))
        else $error("input register lost written value");
    AST_ALL_FULL: assert property (
        status_word[ST_ALL_IN_FULL] == (in_full == 4'hF))
        else $error("all inputs full flag wrong");
    AST_OVERRUN: assert property (
        ext_wr_p && in_full[sel_s] && sw_take == 4'h0
        |=> in_ovr ##1 (in_ovr || $past(ovr_clr)))
        else $error("overrun not flagged or not sticky");
    AST_TAKE_CLEARS: assert property (
        sw_take != 4'h0 && !ext_wr_p |=> (in_full & $past(sw_take)) == 4'h0)
        else $error("software read did not clear full flag");
    AST_ALL_EMPTY: assert property (
        status_word[ST_ALL_OUT_EMPTY] == (out_empty == 4'hF))
        else $error("all outputs empty flag wrong");
    AST_UNDERRUN: assert property (
        ext_rd_p && out_empty[sel_s] && !unr_clr |=> out_unr)
        else $error("underrun not flagged");
    AST_LOAD_CLEARS: assert property (
        sw_load != 4'h0 && !ext_rd_p |=> (out_empty & $past(sw_load)) == 4'h0)
        else $error("software load did not clear empty flag");
    AST_RSVD_ZERO: assert property (
        status_word[13:12] == 2'b00 && status_word[5:4] == 2'b00)
        else $error("reserved status bits not zero");
    AST_ONE_SLOT: assert property (
        ext_wr_p && sw_take == 4'h0
        |=> ((in_full ^ $past(in_full)) & ~$past(sel_hot)) == 4'h0)
        else $error("external write moved another slot flag");

    COV_DUAL_WRITE: cover property (idle && start_dual ##4 idle);
    COV_PORT_READ: cover property (idle && start_in_rd ##4 idle);
    COV_OVERRUN: cover property (ext_wr_p && in_full[sel_s] ##1 in_ovr);
    COV_UNDERRUN: cover property (ext_rd_p && out_empty[sel_s] ##1 out_unr);
endmodule : ppds_top

//--- test/ppds_ext.sv
// Purpose: external party of the parallel port, master or peripheral
// Assumes: strobes held 5 clocks, well past the two-flop sync
// Notes: a released data bus shows the inverse of its last value
`timescale 1ns/1ps
module ppds_ext (
    input wire logic pclk,
    output logic ext_cs_n,
    output logic ext_rd_n,
    output logic ext_wr_n,
    output logic [1:0] ext_addr,
    output logic [15:0] ext_din,
    input wire logic [15:0] ext_dout,
    input wire logic port_rd_n,
    input wire logic port_wr_n
);
    logic [15:0] periph = 16'hA5C3;
    logic [15:0] drv = 16'h0000;
    logic [15:0] got = 16'h0000;
    logic wr_prev = 1'b1;
    int wr_cnt = 0;
    int low_len = 0;
    // peripheral answers at once so the sync has settled before capture
    assign ext_din = port_rd_n ? drv : periph;
    initial begin
        ext_cs_n = 1'b1;
        ext_rd_n = 1'b1;
        ext_wr_n = 1'b1;
        ext_addr = 2'h0;
    end
    always @(posedge pclk) begin
        wr_prev <= port_wr_n;
        if (!port_wr_n) begin
            got <= ext_dout;
            low_len <= wr_prev ? 1 : low_len + 1;
        end
        if (wr_prev && !port_wr_n) begin
            wr_cnt <= wr_cnt + 1;
        end
    end
    task automatic xfer(input bit rd, input logic [1:0] a,
                        input logic [7:0] b, output logic [7:0] q);
        @(posedge pclk);
        ext_addr <= a;
        drv <= {8'h00, b};
        ext_cs_n <= 1'b0;
        ext_rd_n <= !rd;
        ext_wr_n <= rd;
        repeat (5) @(posedge pclk);
        q = ext_dout[7:0];
        ext_cs_n <= 1'b1;
        ext_rd_n <= 1'b1;
        ext_wr_n <= 1'b1;
        drv <= ~drv;
        repeat (4) @(posedge pclk);
    endtask : xfer
endmodule : ppds_ext

//--- test/tb.sv
// Purpose: self-checking bench of the parallel port data/status block
// Assumes: zero-wait APB slave, partner model on the external pins
// Notes: expected flags come from a small bit model kept here
`timescale 1ns/1ps
module tb;
    import ppds_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, ext_cs_n, ext_rd_n, ext_wr_n;
    logic ext_doe, port_rd_n, port_wr_n;
    logic [1:0] ext_addr;
    logic [15:0] ext_din, ext_dout, w;
    logic [7:0] b, q;
    logic [7:0] ib[4];
    bit [3:0] inf = 4'h0;
    bit [3:0] oute = 4'hF;
    bit ovr = 1'b0;
    bit unr = 1'b0;
    int miscompares = 0;
    int total_checks = 0;
    int c;
    always #50 pclk = ~pclk;
    ppds_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_cs_n(ext_cs_n), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
        .ext_addr(ext_addr), .ext_din(ext_din), .ext_dout(ext_dout),
        .ext_doe(ext_doe), .port_rd_n(port_rd_n), .port_wr_n(port_wr_n));
    ppds_ext pm (.pclk(pclk), .ext_cs_n(ext_cs_n), .ext_rd_n(ext_rd_n),
        .ext_wr_n(ext_wr_n), .ext_addr(ext_addr), .ext_din(ext_din),
        .ext_dout(ext_dout), .port_rd_n(port_rd_n), .port_wr_n(port_wr_n));
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input bit wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= wr ? s : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        if (n >= 50) miscompares++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask : rchk
    function automatic logic [31:0] stat();
        logic [31:0] s;
        s = {16'h0, &inf, ovr, 2'b00, inf, &oute, unr, 2'b00, oute};
        return s;
    endfunction : stat
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h528c9f1c));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rchk(ADDR_STATUS, stat());
        rchk(ADDR_OUT_DATA, 32'h0);
        apb(1'b0, 8'h44, 32'h0, 4'h0);
        chk("slave error", 32'h1, {31'h0, err});
        // m[1] picks dual buffer, m[0] picks the narrow bus
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_CONTROL, {29'h0, ~m[0], m[1], 1'b1}, 4'hF);
            w = 16'($urandom);
            c = pm.wr_cnt;
            apb(1'b1, m[1] ? ADDR_IN_DATA : ADDR_OUT_DATA, {16'hFFFF, w},
                4'hF);
            apb(1'b1, m[1] ? ADDR_OUT_DATA : ADDR_IN_DATA, {16'hFFFF, w},
                m[0] ? 4'h2 : 4'h1);
            apb(1'b1, m[1] ? ADDR_OUT_DATA : ADDR_IN_DATA, {16'hFFFF, w},
                m[0] ? 4'h1 : 4'h2);
            @(posedge pclk);
            chk("port drive", 32'h1, {31'h0, ext_doe});
            repeat (5) @(posedge pclk);
            chk("port writes", c + 1, pm.wr_cnt);
            chk("port word", m[0] ? w & 16'h00FF : w, pm.got);
            chk("strobe cycles", STROBE_CYC, pm.low_len);
            rchk(ADDR_IN_DATA, {16'h0, w});
            repeat (6) @(posedge pclk);
            if (!m[1]) begin
                rchk(ADDR_CAPTURE, m[0] ? 32'h00C3 : 32'hA5C3);
            end
        end
        apb(1'b1, ADDR_CONTROL, 32'h0, 4'hF);
        for (int k = 0; k < 4; k++) begin
            ib[k] = 8'($urandom);
            pm.xfer(1'b0, 2'(k), ib[k], q);
            inf[k] = 1'b1;
            rchk(ADDR_STATUS, stat());
        end
        pm.xfer(1'b0, 2'h0, ~ib[0], q);
        ovr = 1'b1;
        rchk(ADDR_STATUS, stat());
        for (int k = 0; k < 4; k++) begin
            rchk(8'(32 + 4 * k), {24'h0, ib[k]});
            inf[k] = 1'b0;
            rchk(ADDR_STATUS, stat());
        end
        for (int k = 0; k < 4; k++) begin
            ib[k] = 8'($urandom);
            apb(1'b1, 8'(32 + 4 * k), {24'h0, ib[k]}, 4'h1);
            oute[k] = 1'b0;
            rchk(ADDR_STATUS, stat());
        end
        rchk(ADDR_OUT_DATA, {16'h0, ib[1], ib[0]});
        for (int k = 0; k < 4; k++) begin
            pm.xfer(1'b1, 2'(k), 8'h00, q);
            chk("slave byte", {24'h0, ib[k]}, {24'h0, q});
            chk("slave release", 32'h0, {31'h0, ext_doe});
            oute[k] = 1'b1;
            rchk(ADDR_STATUS, stat());
        end
        pm.xfer(1'b1, 2'h2, 8'h00, q);
        unr = 1'b1;
        rchk(ADDR_STATUS, stat());
        apb(1'b1, ADDR_STATUS, 32'h0, 4'h3);
        ovr = 1'b0;
        unr = 1'b0;
        rchk(ADDR_STATUS, stat());
        complete_run();
    end
endmodule : tb
